// *** quadrature_position_decoder.sv ***
// Quadrature / single-phase position decoder with AHB-Lite register slave.
// Assumes sensor inputs are synchronous to hclk; one clock domain.
`timescale 1ns/1ps

module quadrature_position_decoder
	import qpd_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic quad_in_a,
	input wire logic quad_in_b,
	input wire logic index_in,
	input wire logic home_in,
	input wire logic trigger_in,
	input wire logic [3:1] capture_inputs,
	output logic irq_q,
	output logic [3:0] cmp_out_q,
	output logic dir_q
);

	// ==========================================================
	// Bus address phase capture
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] ctrl_q;
	logic [NUM_FLAGS-1:0] flags_q;
	logic [NUM_FLAGS-1:0] irq_en_q;
	logic [31:0] init_q;
	logic [31:0] modulus_q;
	logic [31:0] cmp_q [4];
	logic [31:0] pos_q;
	logic [15:0] pos_delta_q;
	logic [15:0] edge_timer_q;
	logic [15:0] edge_hold_q;
	logic [15:0] period_q;
	logic [15:0] period_buf_q;
	logic [15:0] period_hold_q;
	logic [3:0] raw_q;
	logic [3:0] filt_q;
	logic dir_hold_q;
	logic [15:0] pre_cnt_q;
	logic [15:0] wdog_q;
	logic tick;
	logic acc;
	logic rd_delta;

	assign acc = hsel & hready & htrans[1];
	assign rd_delta = acc & ~hwrite & (haddr[7:0] == OFS_POS_DELTA);

	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = wr_pend_q & (wr_addr_q == ofs);
	endfunction : wr_hit

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= acc & hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// ==========================================================
	// Read data, zero-wait OKAY answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (acc & ~hwrite) begin
			case (haddr[7:0])
				OFS_CTRL: hrdata <= ctrl_q;
				OFS_FLAGS: hrdata <= 32'(flags_q);
				OFS_IRQ_EN: hrdata <= 32'(irq_en_q);
				OFS_STATUS: hrdata <= {18'h0_0000, dir_q, dir_hold_q, cmp_out_q, filt_q, raw_q};
				OFS_POS: hrdata <= pos_q;
				OFS_POS_DELTA: hrdata <= {16'h0000, pos_delta_q};
				OFS_INIT: hrdata <= init_q;
				OFS_MODULUS: hrdata <= modulus_q;
				OFS_EDGE_TIMER: hrdata <= {16'h0000, edge_timer_q};
				OFS_EDGE_HOLD: hrdata <= {16'h0000, edge_hold_q};
				OFS_PERIOD: hrdata <= {16'h0000, period_q};
				OFS_PERIOD_BUF: hrdata <= {16'h0000, period_buf_q};
				OFS_PERIOD_HOLD: hrdata <= {16'h0000, period_hold_q};
				8'h40, 8'h44, 8'h48, 8'h4C: hrdata <= cmp_q[haddr[3:2]];
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RESET;
			irq_en_q <= '0;
			init_q <= 32'h0000_0000;
			modulus_q <= 32'h0000_0000;
			cmp_q <= '{default: 32'h0000_0000};
		end else begin
			if (wr_hit(OFS_CTRL))
				ctrl_q <= hwdata;
			if (wr_hit(OFS_IRQ_EN))
				irq_en_q <= hwdata[NUM_FLAGS-1:0];
			if (wr_hit(OFS_INIT))
				init_q <= hwdata;
			if (wr_hit(OFS_MODULUS))
				modulus_q <= hwdata;
			for (int i = 0; i < 4; i++) begin
				if (wr_pend_q & (wr_addr_q == OFS_CMP0 + 8'(4 * i)))
					cmp_q[i] <= hwdata;
			end
		end
	end

	// ==========================================================
	// Input sampling, edge detection and mode decode
	logic single_phase;
	sp_mode_e sp_mode;
	init_edge_e home_mode;
	init_edge_e index_mode;
	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic b_fall;
	logic phase_edge;
	logic home_rise;
	logic home_fall;
	logic idx_rise;
	logic idx_fall;

	assign single_phase = ctrl_q[CTRL_SINGLE_PHASE];
	assign sp_mode = sp_mode_e'(ctrl_q[CTRL_SP_MODE_LO +: 2]);
	assign home_mode = init_edge_e'(ctrl_q[CTRL_HOME_MODE_LO +: 2]);
	assign index_mode = init_edge_e'(ctrl_q[CTRL_INDEX_MODE_LO +: 2]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_q <= 4'h0;
			filt_q <= 4'h0;
		end else begin
			// Order: home, index, B, A; every mode reads the same four pins
			raw_q <= {quad_in_a, quad_in_b, index_in, home_in};
			filt_q <= raw_q;
		end
	end

	assign a_rise = raw_q[3] & ~filt_q[3];
	assign a_fall = ~raw_q[3] & filt_q[3];
	assign b_rise = raw_q[2] & ~filt_q[2];
	assign b_fall = ~raw_q[2] & filt_q[2];
	assign idx_rise = raw_q[1] & ~filt_q[1];
	assign idx_fall = ~raw_q[1] & filt_q[1];
	assign home_rise = raw_q[0] & ~filt_q[0];
	assign home_fall = ~raw_q[0] & filt_q[0];
	assign phase_edge = a_rise | a_fall | b_rise | b_fall;

	// ==========================================================
	// Step and direction decode
	logic step;
	logic up_raw;
	logic up;
	logic simult;

	assign simult = (a_rise | a_fall) & (b_rise | b_fall);

	always_comb begin
		step = 1'b0;
		up_raw = 1'b1;
		if (!single_phase) begin
			step = phase_edge & ~simult;
			// A leads B: A changes to differ from B is forward
			up_raw = (a_rise | a_fall) ? (raw_q[3] != raw_q[2]) : (raw_q[3] == raw_q[2]);
		end else begin
			case (sp_mode)
				SP_SIGNED_SINGLE: begin
					step = a_rise;
					up_raw = ~raw_q[2];
				end
				SP_SIGNED_DOUBLE: begin
					step = a_rise | a_fall;
					up_raw = ~raw_q[2];
				end
				SP_UPDOWN: begin
					step = a_rise ^ b_rise;
					up_raw = a_rise;
				end
				default: begin
					step = 1'b0;
					up_raw = 1'b1;
				end
			endcase
		end
	end

	assign up = up_raw ^ ctrl_q[CTRL_REVERSE];

	// ==========================================================
	// Position and difference counters
	logic home_init;
	logic idx_init;
	logic roll_over;
	logic roll_under;
	logic modulo;

	assign modulo = ctrl_q[CTRL_MODULO_EN];
	assign home_init = ((home_mode == EDGE_RISE) & home_rise) | ((home_mode == EDGE_FALL) & home_fall);
	assign idx_init = ((index_mode == EDGE_RISE) & idx_rise) | ((index_mode == EDGE_FALL) & idx_fall);
	assign roll_over = step & up & (modulo ? (pos_q == modulus_q) : (pos_q == POS_ALL_ONES));
	assign roll_under = step & ~up & (modulo ? (pos_q == init_q) : (pos_q == 32'h0000_0000));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_q <= 32'h0000_0000;
		end else if (wr_hit(OFS_POS)) begin
			pos_q <= hwdata;
		end else if (home_init | idx_init) begin
			pos_q <= init_q;
		end else if (roll_over) begin
			pos_q <= modulo ? init_q : 32'h0000_0000;
		end else if (roll_under) begin
			pos_q <= modulo ? modulus_q : POS_ALL_ONES;
		end else if (step) begin
			pos_q <= up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
		end
	end

	// Difference counter follows the inputs, not the reverse bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_delta_q <= 16'h0000;
		end else if (rd_delta) begin
			pos_delta_q <= 16'h0000;
		end else if (step) begin
			pos_delta_q <= up_raw ? pos_delta_q + 16'h0001 : pos_delta_q - 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_q <= 1'b1;
			dir_hold_q <= 1'b1;
		end else begin
			if (step)
				dir_q <= up;
			if (rd_delta)
				dir_hold_q <= dir_q;
		end
	end

	// ==========================================================
	// Prescaled timebase and period measurement
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt_q <= 16'h0000;
		end else begin
			pre_cnt_q <= pre_cnt_q + 16'h0001;
		end
	end

	// Prescale field n gives a tick every 2^n clocks
	assign tick = (ctrl_q[CTRL_PRESCALE_LO +: 4] == 4'h0) ? 1'b1
		: ((pre_cnt_q & ((16'h0001 << ctrl_q[CTRL_PRESCALE_LO +: 4]) - 16'h0001)) == 16'h0000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_timer_q <= 16'h0000;
		end else if (phase_edge) begin
			edge_timer_q <= 16'h0000;
		end else if (tick && edge_timer_q != TIMER_MAX) begin
			edge_timer_q <= edge_timer_q + 16'h0001;
		end
	end

	logic period_stop_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_q <= 16'h0000;
			period_stop_q <= 1'b0;
		end else if (rd_delta) begin
			period_q <= edge_timer_q;
			period_stop_q <= 1'b0;
		end else if (phase_edge) begin
			period_stop_q <= 1'b0;
		end else if (tick && !period_stop_q) begin
			if (period_q == TIMER_MAX)
				period_stop_q <= 1'b1;
			else
				period_q <= period_q + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			period_buf_q <= 16'h0000;
			period_hold_q <= 16'h0000;
			edge_hold_q <= 16'h0000;
		end else begin
			if (phase_edge)
				period_buf_q <= period_q;
			if (rd_delta) begin
				period_hold_q <= period_buf_q;
				edge_hold_q <= edge_timer_q;
			end
		end
	end

	// ==========================================================
	// Watchdog, compare and event flags
	logic [NUM_FLAGS-1:0] ev;
	logic [NUM_FLAGS-1:0] clr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdog_q <= 16'h0000;
		end else if (step || wdog_q == WDOG_TIMEOUT) begin
			wdog_q <= 16'h0000;
		end else if (tick) begin
			wdog_q <= wdog_q + 16'h0001;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cmp
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					cmp_out_q[g] <= 1'b0;
				else
					cmp_out_q[g] <= (pos_q == cmp_q[g]);
			end
			assign ev[FLG_CMP_LO + g] = (pos_q == cmp_q[g]) & ~cmp_out_q[g];
		end
	endgenerate

	assign ev[FLG_HOME] = home_rise | home_fall;
	assign ev[FLG_INDEX] = idx_rise | idx_fall;
	assign ev[FLG_WDOG] = (wdog_q == WDOG_TIMEOUT);
	assign ev[FLG_SIMULT] = ~single_phase & simult;
	assign ev[FLG_DIR] = step & (up != dir_q);
	assign ev[FLG_ROVER] = roll_over;
	assign ev[FLG_RUNDER] = roll_under;
	assign clr = (wr_pend_q && wr_addr_q == OFS_FLAGS) ? hwdata[NUM_FLAGS-1:0] : '0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= '0;
			irq_q <= 1'b0;
		end else begin
			flags_q <= (flags_q & ~clr) | ev;
			irq_q <= |(((flags_q & ~clr) | ev) & irq_en_q);
		end
	end

	// ==========================================================
	// Assertions
	property p_edge_hold;
		@(posedge hclk) disable iff (!hresetn) rd_delta |=> edge_hold_q == $past(edge_timer_q);
	endproperty
	a_edge_hold: assert property (p_edge_hold) else $error("edge hold not loaded");

	property p_period_load;
		@(posedge hclk) disable iff (!hresetn) rd_delta |=> period_q == $past(edge_timer_q);
	endproperty
	a_period_load: assert property (p_period_load) else $error("period not loaded");

	property p_period_sat;
		@(posedge hclk) disable iff (!hresetn) (period_q == TIMER_MAX && !rd_delta) |=> period_q == TIMER_MAX;
	endproperty
	a_period_sat: assert property (p_period_sat) else $error("period wrapped");

	property p_buf;
		@(posedge hclk) disable iff (!hresetn) phase_edge |=> period_buf_q == $past(period_q);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer not updated");

	property p_hold;
		@(posedge hclk) disable iff (!hresetn) rd_delta |=> period_hold_q == $past(period_buf_q);
	endproperty
	a_hold: assert property (p_hold) else $error("period hold not updated");

	property p_timer_clr;
		@(posedge hclk) disable iff (!hresetn) phase_edge |=> edge_timer_q == 16'h0000;
	endproperty
	a_timer_clr: assert property (p_timer_clr) else $error("edge timer not cleared");

	property p_rover;
		@(posedge hclk) disable iff (!hresetn)
			(roll_over && !(wr_pend_q && wr_addr_q == OFS_POS) && !home_init && !idx_init)
			|=> flags_q[FLG_ROVER] && pos_q == (modulo ? init_q : 32'h0000_0000);
	endproperty
	a_rover: assert property (p_rover) else $error("roll-over wrong");

	property p_runder;
		@(posedge hclk) disable iff (!hresetn) roll_under |=> flags_q[FLG_RUNDER];
	endproperty
	a_runder: assert property (p_runder) else $error("roll-under flag missing");

	property p_sticky;
		@(posedge hclk) disable iff (!hresetn) (flags_q[FLG_HOME] && !clr[FLG_HOME]) |=> flags_q[FLG_HOME];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");

	property p_irq;
		@(posedge hclk) disable iff (!hresetn) ##1 irq_q == |(flags_q & $past(irq_en_q));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	c_rover: cover property (@(posedge hclk) disable iff (!hresetn) roll_over);
	c_rd_delta: cover property (@(posedge hclk) disable iff (!hresetn) rd_delta ##1 phase_edge);
	c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq_q));

endmodule : quadrature_position_decoder

// *** qpd_pkg.sv ***
// Constants, register map and mode types for the quadrature position decoder.
// Assumes a single 20 MHz clock and an AHB-Lite register bus.
//
// Behaviour
// - Reading the difference counter copies the edge-interval timer into its hold.
// - Difference-period counter advances on each prescaled tick.
// - Reading the difference counter loads the edge-interval timer into difference-period counter.
// - Difference-period counter stops at all ones until the difference counter is read.
// - Every phase edge copies difference-period counter into its buffer.
// - Reading the difference counter copies the buffer into the difference-period hold.
// - Separate flags for home, index, watchdog, simultaneous change and direction change.
// - Roll-over flag on wrap all ones to zero, or modulus to initial.
// - Roll-under flag on wrap zero to all ones, or initial to modulus.
// - Four compare channels each flag on position equal to compare value.
// - Every event flag has its own interrupt enable.
// - Status shows raw and filtered home, index and both phase levels.
// - Status also shows compare outputs, direction and held direction.
// - Home input leaves counter, or initialises it on rising or falling edge.
// - Index input leaves counter, or initialises it on rising or falling edge.
// - Single-phase bit and single-phase mode field choose one of four modes.
// - All modes use index and home for initialisation.
// - Quadrature counts up when A leads B, down when A trails.
// - Signed single-edge: step on A rising, B gives direction.
// - Signed double-edge: step on both A edges, B gives direction.
// - Up/down pulse: A rising counts up, B rising counts down.
// - Reverse bit set makes the position counter count the opposite way.
// - Edge-interval timer counts ticks, clears on phase edge, stops at all ones.
// - Event flags are cleared by writing one.

package qpd_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] OFS_IRQ_EN = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_POS = 8'h10;
	localparam logic [7:0] OFS_POS_DELTA = 8'h14;
	localparam logic [7:0] OFS_INIT = 8'h18;
	localparam logic [7:0] OFS_MODULUS = 8'h1C;
	localparam logic [7:0] OFS_EDGE_TIMER = 8'h20;
	localparam logic [7:0] OFS_EDGE_HOLD = 8'h24;
	localparam logic [7:0] OFS_PERIOD = 8'h28;
	localparam logic [7:0] OFS_PERIOD_BUF = 8'h2C;
	localparam logic [7:0] OFS_PERIOD_HOLD = 8'h30;
	localparam logic [7:0] OFS_CMP0 = 8'h40;

	// ==========================================================
	// Control register fields
	localparam int CTRL_SINGLE_PHASE = 0;
	localparam int CTRL_OPERATION = 1;
	localparam int CTRL_REVERSE = 2;
	localparam int CTRL_MODULO_EN = 3;
	localparam int CTRL_HOME_MODE_LO = 4;
	localparam int CTRL_INDEX_MODE_LO = 6;
	localparam int CTRL_SP_MODE_LO = 8;
	localparam int CTRL_PRESCALE_LO = 12;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ==========================================================
	// Flag bit positions (flag and enable registers share them)
	localparam int FLG_HOME = 0;
	localparam int FLG_INDEX = 1;
	localparam int FLG_WDOG = 2;
	localparam int FLG_SIMULT = 3;
	localparam int FLG_DIR = 4;
	localparam int FLG_ROVER = 5;
	localparam int FLG_RUNDER = 6;
	localparam int FLG_CMP_LO = 7;
	localparam int NUM_FLAGS = 11;

	// ==========================================================
	// Counter widths and limits
	localparam logic [15:0] TIMER_MAX = 16'hFFFF;
	localparam logic [15:0] WDOG_TIMEOUT = 16'hFFFF;
	localparam logic [31:0] POS_ALL_ONES = 32'hFFFF_FFFF;

	typedef enum logic [1:0] {
		EDGE_OFF,
		EDGE_RISE,
		EDGE_FALL,
		EDGE_RSVD
	} init_edge_e;

	typedef enum logic [1:0] {
		SP_SIGNED_SINGLE,
		SP_SIGNED_DOUBLE,
		SP_UPDOWN,
		SP_RSVD
	} sp_mode_e;

endpackage : qpd_pkg

// *** qpd_sensor.sv ***
// Sensor model: quadrature encoder with index and home lines.
// Assumes the decoder samples its pins on rising hclk edges.
`timescale 1ns/1ps

module qpd_sensor (
	input wire logic hclk,
	output logic quad_in_a,
	output logic quad_in_b,
	output logic index_in,
	output logic home_in
);
	// ==========================================================
	// Pin driver
	logic [1:0] ph_q = 2'h0;

	initial begin
		{quad_in_a, quad_in_b, index_in, home_in} = 4'h0;
	end

	// Change after an edge, then hold long enough to be decoded
	task automatic pins(input logic [3:0] v);
		@(posedge hclk);
		{quad_in_a, quad_in_b, index_in, home_in} <= v;
		ph_q = {v[2], v[3] ^ v[2]};
		repeat (8) @(posedge hclk);
	endtask : pins

	// One quadrature state a step; A leads B when moving up
	task automatic quad(input logic up, input int n);
		logic [1:0] s;
		repeat (n) begin
			s = up ? ph_q + 2'h1 : ph_q - 2'h1;
			pins({s[1] ^ s[0], s[1], index_in, home_in});
		end
	endtask : quad
endmodule : qpd_sensor

// *** quadrature_position_decoder_bench.sv ***
// Self-checking bench for the quadrature position decoder.
// Assumes a zero-wait AHB-Lite slave and the sensor model beside it.
`timescale 1ns/1ps

module quadrature_position_decoder_bench;
	import qpd_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq_q, dir_q;
	logic [3:0] cmp_out_q;
	logic quad_in_a, quad_in_b, index_in, home_in;
	logic trigger_in = 1'b0;
	logic [3:1] capture_inputs = 3'h0;
	logic [31:0] v, t1, lo, hi;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;

	quadrature_position_decoder i_quadrature_position_decoder (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .quad_in_a, .quad_in_b, .index_in, .home_in,
		.trigger_in, .capture_inputs, .irq_q, .cmp_out_q, .dir_q
	);

	qpd_sensor i_qpd_sensor (.hclk, .quad_in_a, .quad_in_b, .index_in, .home_in);

	initial begin
		forever #25 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// ==========================================================
	// Bus and check tasks
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		xfer(1'b0, a, 32'h0000_0000, r);
	endtask : rd

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t: saw %h, expected %h", $time, s, e);
		end
	endtask : chk

	task automatic settle();
		repeat (2) @(posedge hclk);
		#1;
	endtask : settle

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// Tests
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd(OFS_CTRL, v);
		chk(v, CTRL_RESET);
		chk(32'(hresp), 32'h0);
		rd(8'h3C, v);
		chk(v, 32'h0000_0000);
		chk(32'(dir_q), 32'h1);
		$display("test reset done");
		i_qpd_sensor.quad(1'b1, 8);
		rd(OFS_POS, v);
		chk(v, 32'h0000_0008);
		rd(OFS_POS_DELTA, v);
		chk(v, 32'h0000_0008);
		i_qpd_sensor.quad(1'b0, 3);
		rd(OFS_POS, v);
		chk(v, 32'h0000_0005);
		rd(OFS_POS_DELTA, v);
		chk(v, 32'h0000_FFFD);
		rd(OFS_FLAGS, v);
		chk(32'(v[FLG_DIR]), 32'h1);
		wr(OFS_FLAGS, 32'h0000_0010);
		rd(OFS_FLAGS, v);
		chk(32'(v[FLG_DIR]), 32'h0);
		wr(OFS_CTRL, 32'h0000_0004);
		i_qpd_sensor.quad(1'b1, 2);
		rd(OFS_POS, v);
		chk(v, 32'h0000_0003);
		rd(OFS_POS_DELTA, v);
		chk(v, 32'h0000_0002);
		$display("test quadrature done");
		wr(OFS_INIT, 32'h0000_0002);
		wr(OFS_MODULUS, 32'h0000_0005);
		for (int m = 0; m < 2; m++) begin
			lo = m ? 32'h0000_0002 : 32'h0000_0000;
			hi = m ? 32'h0000_0005 : POS_ALL_ONES;
			wr(OFS_CTRL, m ? 32'h0000_0008 : 32'h0000_0000);
			wr(OFS_POS, lo);
			wr(OFS_FLAGS, 32'h0000_07FF);
			i_qpd_sensor.quad(1'b0, 1);
			rd(OFS_POS, v);
			chk(v, hi);
			rd(OFS_FLAGS, v);
			chk(32'(v[6:5]), 32'h2);
			wr(OFS_FLAGS, 32'h0000_07FF);
			i_qpd_sensor.quad(1'b1, 1);
			rd(OFS_POS, v);
			chk(v, lo);
			rd(OFS_FLAGS, v);
			chk(32'(v[6:5]), 32'h1);
		end
		$display("test wrap done");
		wr(OFS_CTRL, 32'h0000_0000);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CMP0 + 8'(4 * c), 32'h0000_0020 + 32'(c));
		end
		wr(OFS_POS, 32'h0000_001F);
		wr(OFS_FLAGS, 32'h0000_07FF);
		for (int c = 0; c < 4; c++) begin
			i_qpd_sensor.quad(1'b1, 1);
			chk(32'(cmp_out_q), 32'(4'h1 << c));
			rd(OFS_STATUS, v);
			chk(32'(v[13:8]), 32'h20 | 32'(4'h1 << c));
		end
		i_qpd_sensor.quad(1'b1, 1);
		rd(OFS_FLAGS, v);
		chk(32'(v[10:7]), 32'hF);
		chk(32'(irq_q), 32'h0);
		wr(OFS_IRQ_EN, 32'h0000_0080);
		settle();
		chk(32'(irq_q), 32'h1);
		wr(OFS_IRQ_EN, 32'h0000_0000);
		settle();
		chk(32'(irq_q), 32'h0);
		wr(OFS_IRQ_EN, 32'h0000_0080);
		wr(OFS_FLAGS, 32'h0000_0080);
		settle();
		chk(32'(irq_q), 32'h0);
		$display("test compare done");
		for (int sp = 0; sp < 3; sp++) begin
			wr(OFS_CTRL, 32'h0000_0001 | (32'(sp & 1) << 1) | (32'(sp) << 8));
			i_qpd_sensor.pins(4'h0);
			wr(OFS_POS, 32'h0000_0100);
			repeat (2) begin
				i_qpd_sensor.pins(4'h8);
				i_qpd_sensor.pins(4'h0);
			end
			rd(OFS_POS, v);
			lo = (sp == 1) ? 32'h0000_0004 : 32'h0000_0002;
			chk(32'(v === 32'h0000_0100 + lo || (sp != 2 && v === 32'h0000_0100 - lo)), 32'h1);
			if (sp == 2) begin
				repeat (2) begin
					i_qpd_sensor.pins(4'h4);
					i_qpd_sensor.pins(4'h0);
				end
			end else begin
				i_qpd_sensor.pins(4'h4);
				repeat (2) begin
					i_qpd_sensor.pins(4'hC);
					i_qpd_sensor.pins(4'h4);
				end
				i_qpd_sensor.pins(4'h0);
			end
			rd(OFS_POS, v);
			chk(v, 32'h0000_0100);
		end
		$display("test single phase done");
		for (int k = 0; k < 2; k++) begin
			wr(OFS_CTRL, k ? 32'h0000_0080 : 32'h0000_0010);
			wr(OFS_POS, 32'h0000_0100);
			wr(OFS_FLAGS, 32'h0000_07FF);
			i_qpd_sensor.pins(k ? 4'h2 : 4'h1);
			rd(OFS_POS, v);
			chk(v, k ? 32'h0000_0100 : 32'h0000_0002);
			i_qpd_sensor.pins(4'h0);
			rd(OFS_POS, v);
			chk(v, 32'h0000_0002);
			rd(OFS_FLAGS, v);
			chk(32'(v[k]), 32'h1);
		end
		wr(OFS_CTRL, 32'h0000_0000);
		wr(OFS_POS, 32'h0000_0100);
		wr(OFS_FLAGS, 32'h0000_07FF);
		trigger_in <= 1'b1;
		capture_inputs <= 3'h7;
		i_qpd_sensor.pins(4'hC);
		rd(OFS_POS, v);
		chk(v, 32'h0000_0100);
		rd(OFS_FLAGS, v);
		chk(32'(v[FLG_SIMULT]), 32'h1);
		trigger_in <= 1'b0;
		capture_inputs <= 3'h0;
		i_qpd_sensor.pins(4'h9);
		rd(OFS_STATUS, v);
		chk(32'(v[7:0]), 32'h99);
		$display("test inputs done");
		rd(OFS_EDGE_TIMER, t1);
		rd(OFS_EDGE_TIMER, v);
		chk(v - t1, 32'h3);
		rd(OFS_PERIOD, t1);
		rd(OFS_PERIOD, v);
		chk(v - t1, 32'h3);
		rd(OFS_EDGE_TIMER, t1);
		rd(OFS_POS_DELTA, v);
		rd(OFS_EDGE_HOLD, v);
		chk(32'((v - t1) inside {[32'h2:32'h4]}), 32'h1);
		rd(OFS_PERIOD, v);
		chk(32'((v - t1) inside {[32'h8:32'hA]}), 32'h1);
		repeat (66000) @(posedge hclk);
		rd(OFS_EDGE_TIMER, v);
		chk(v, 32'h0000_FFFF);
		rd(OFS_PERIOD, v);
		chk(v, 32'h0000_FFFF);
		rd(OFS_FLAGS, v);
		chk(32'(v[FLG_WDOG]), 32'h1);
		i_qpd_sensor.pins(4'h1);
		rd(OFS_PERIOD_BUF, v);
		chk(v, 32'h0000_FFFF);
		rd(OFS_EDGE_TIMER, v);
		chk(32'(v < 32'h0000_0020), 32'h1);
		rd(OFS_POS_DELTA, v);
		rd(OFS_PERIOD, v);
		chk(32'(v < 32'h0000_0040), 32'h1);
		rd(OFS_PERIOD_HOLD, v);
		chk(v, 32'h0000_FFFF);
		$display("test period done");
		finish_test();
	end
endmodule : quadrature_position_decoder_bench
